// ===== verilog/fcc_map.vh
// Register map, field positions, reset values and command codes of the
// flash command controller. Definitions only; included by fcc_top.v.
`ifndef FCC_MAP_VH
`define FCC_MAP_VH

// Byte offsets on the APB register bus
`define FCC_OFS_CONFIG      8'h00
`define FCC_OFS_PROTECTION  8'h04
`define FCC_OFS_STATUS      8'h08
`define FCC_OFS_COMMAND     8'h0c
`define FCC_OFS_DIVIDER     8'h10

// flash_config fields
`define FCC_CFG_KEY_WR_EN   5
// flash_protection fields
`define FCC_PROT_DISABLE    0
// flash_status fields
`define FCC_ST_BEF          7
`define FCC_ST_CCF          6
`define FCC_ST_PVIOL        5
`define FCC_ST_ACCERR       4
`define FCC_ST_BLANK        2
// flash_clock_divider fields
`define FCC_DIV_LOADED      7
`define FCC_DIV_PRESCALE    6

// Reset values
`define FCC_RST_CONFIG      8'h00
`define FCC_RST_COMMAND     8'h00
`define FCC_RST_DIVIDER     8'h00

// Command codes
`define FCC_CMD_BLANK       8'h05
`define FCC_CMD_BYTE_PROG   8'h20
`define FCC_CMD_BURST_PROG  8'h25
`define FCC_CMD_PAGE_ERASE  8'h40
`define FCC_CMD_MASS_ERASE  8'h41

// Backdoor key address range and protection boundary fill
`define FCC_KEY_BASE        16'hffb0
`define FCC_KEY_LAST        16'hffb7
`define FCC_PROT_FILL       9'h1ff

// Flash-clock pulses per operation and prescale count
`define FCC_PULSES_PROG     16'd9
`define FCC_PULSES_BURST    16'd4
`define FCC_PULSES_PAGE     16'd4000
`define FCC_PULSES_MASS     16'd20000
`define FCC_PULSES_BLANK    16'd1
`define FCC_PRESCALE_LAST   3'd7

`endif

// ===== verilog/fcc_top.v
// Flash command controller: APB register file, command sequencer with a
// one-deep burst buffer, protection check and flash-clock pulse engine.
// Assumes array-write strobes and stop/debug inputs come from mclk logic;
// the flash array itself sits outside and follows arr_* outputs.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "fcc_map.vh"

module fcc_top #(
    parameter PULSES_PAGE = `FCC_PULSES_PAGE,
    parameter PULSES_MASS = `FCC_PULSES_MASS
) (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    input  wire        arr_wr_en,
    input  wire [15:0] arr_wr_addr,
    input  wire [7:0]  arr_wr_data,
    input  wire [7:0]  nonvolatile_protect_byte,
    input  wire        dbg_prot_wr,
    input  wire [7:0]  dbg_prot_data,
    input  wire        stop_req,
    input  wire        arr_blank,
    output reg         arr_busy_ff,
    output reg  [7:0]  arr_cmd_ff,
    output reg  [15:0] arr_addr_ff,
    output reg  [7:0]  arr_data_ff,
    output reg         arr_pulse_ff,
    output reg         key_wr_ff,
    output reg  [2:0]  key_idx_ff,
    output reg  [7:0]  key_data_ff
);

    // Sequence states: waiting for array write, for command, for launch
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_DATA = 3'b010;
    localparam [2:0] S_CMD  = 3'b100;

    reg  [2:0]  seq_ff;
    reg  [7:0]  flash_config_ff;
    reg  [7:0]  flash_protection_ff;
    reg  [7:0]  flash_command_ff;
    reg  [7:0]  flash_clock_divider_ff;
    reg         buffer_empty_flag_ff;
    reg         command_complete_flag_ff;
    reg         protection_violation_flag_ff;
    reg         access_error_flag_ff;
    reg         blank_result_flag_ff;
    reg  [15:0] seq_addr_ff;
    reg  [7:0]  seq_data_ff;
    reg  [15:0] buf_addr_ff;
    reg  [7:0]  buf_data_ff;
    reg  [7:0]  buf_cmd_ff;
    reg  [2:0]  pre_cnt_ff;
    reg  [5:0]  div_cnt_ff;
    reg  [15:0] pulse_cnt_ff;

    wire        acc_wr;
    wire        key_en;
    wire        in_key_range;
    wire        seq_wr;
    wire        cmd_wr;
    wire        launch_wr;
    wire        stop_abort;
    wire        fclk_tick;
    wire        exe_done;
    wire [15:0] boundary;
    wire        prot_hit;
    wire        cmd_legal;
    wire        cmd_is_burst;
    reg  [15:0] pulses_for;
    reg  [31:0] rd_mux;
    reg         rd_ok;

    // APB access phase; writes act here, when pready is already high
    assign acc_wr = psel & penable & pready_ff & pwrite;

    // Array writes in the key range go to key logic only when enabled
    assign key_en       = flash_config_ff[`FCC_CFG_KEY_WR_EN];
    assign in_key_range = (arr_wr_addr >= `FCC_KEY_BASE) && (arr_wr_addr <= `FCC_KEY_LAST);
    assign seq_wr       = arr_wr_en & ~(key_en & in_key_range);
    assign cmd_wr       = acc_wr & (paddr == `FCC_OFS_COMMAND);
    assign launch_wr    = acc_wr & (paddr == `FCC_OFS_STATUS) & pwdata[`FCC_ST_BEF];
    assign stop_abort   = stop_req & arr_busy_ff;

    // Command decode
    assign cmd_legal = (flash_command_ff == `FCC_CMD_BLANK) |
                       (flash_command_ff == `FCC_CMD_BYTE_PROG) |
                       (flash_command_ff == `FCC_CMD_BURST_PROG) |
                       (flash_command_ff == `FCC_CMD_PAGE_ERASE) |
                       (flash_command_ff == `FCC_CMD_MASS_ERASE);
    assign cmd_is_burst = (flash_command_ff == `FCC_CMD_BURST_PROG);

    // Protected region is everything above {select, 9 ones}
    assign boundary = {flash_protection_ff[7:1], `FCC_PROT_FILL};
    assign prot_hit = ~flash_protection_ff[`FCC_PROT_DISABLE] &
                      (flash_command_ff != `FCC_CMD_BLANK) &
                      ((flash_command_ff == `FCC_CMD_MASS_ERASE) | (seq_addr_ff > boundary));

    // Flash clock tick: bus clock, optional divide by 8, then DIV+1
    assign fclk_tick = (div_cnt_ff == 6'd0) &
                       (~flash_clock_divider_ff[`FCC_DIV_PRESCALE] | (pre_cnt_ff == 3'd0));
    assign exe_done  = arr_busy_ff & fclk_tick & (pulse_cnt_ff == 16'd1);

    // Pulses needed by the command leaving the buffer
    always @* begin
        pulses_for = `FCC_PULSES_BLANK;
        case (buf_cmd_ff)
            `FCC_CMD_BYTE_PROG:  pulses_for = `FCC_PULSES_PROG;
            `FCC_CMD_BURST_PROG: pulses_for = `FCC_PULSES_BURST;
            `FCC_CMD_PAGE_ERASE: pulses_for = PULSES_PAGE[15:0];
            `FCC_CMD_MASS_ERASE: pulses_for = PULSES_MASS[15:0];
            default:             pulses_for = `FCC_PULSES_BLANK;
        endcase
    end

    // Read mux; unmapped addresses answer with an error
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (paddr == `FCC_OFS_CONFIG) begin
            rd_mux[7:0] = flash_config_ff;
        end else if (paddr == `FCC_OFS_PROTECTION) begin
            rd_mux[7:0] = flash_protection_ff;
        end else if (paddr == `FCC_OFS_STATUS) begin
            rd_mux[`FCC_ST_BEF]    = buffer_empty_flag_ff;
            rd_mux[`FCC_ST_CCF]    = command_complete_flag_ff;
            rd_mux[`FCC_ST_PVIOL]  = protection_violation_flag_ff;
            rd_mux[`FCC_ST_ACCERR] = access_error_flag_ff;
            rd_mux[`FCC_ST_BLANK]  = blank_result_flag_ff;
        end else if (paddr == `FCC_OFS_COMMAND) begin
            rd_mux[7:0] = flash_command_ff;
        end else if (paddr == `FCC_OFS_DIVIDER) begin
            rd_mux[7:0] = flash_clock_divider_ff;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // APB slave: one wait-free access phase after each setup cycle
    always @(posedge mclk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~rd_ok;
            prdata_ff  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Protection: loaded while reset is held, then only debug may change it
    always @(posedge mclk) begin
        if (sys_rst) begin
            flash_protection_ff <= nonvolatile_protect_byte;
        end else if (dbg_prot_wr) begin
            flash_protection_ff <= dbg_prot_data;
        end
    end

    // Config and divider registers; divider write enables program/erase
    always @(posedge mclk) begin
        if (sys_rst) begin
            flash_config_ff        <= `FCC_RST_CONFIG;
            flash_clock_divider_ff <= `FCC_RST_DIVIDER;
        end else begin
            if (acc_wr && paddr == `FCC_OFS_CONFIG) begin
                flash_config_ff <= pwdata[7:0];
            end
            if (acc_wr && paddr == `FCC_OFS_DIVIDER) begin
                flash_clock_divider_ff <= {1'b1, pwdata[6:0]};
            end
        end
    end

    // Backdoor key writes are forwarded, never sequenced
    always @(posedge mclk) begin
        if (sys_rst) begin
            key_wr_ff   <= 1'b0;
            key_idx_ff  <= 3'd0;
            key_data_ff <= 8'h00;
        end else begin
            key_wr_ff <= arr_wr_en & key_en & in_key_range;
            if (arr_wr_en) begin
                key_idx_ff  <= arr_wr_addr[2:0];
                key_data_ff <= arr_wr_data;
            end
        end
    end

    // Flash clock divider counters run freely from the divider register
    always @(posedge mclk) begin
        if (sys_rst) begin
            pre_cnt_ff <= 3'd0;
            div_cnt_ff <= 6'd0;
        end else begin
            pre_cnt_ff <= (pre_cnt_ff == 3'd0) ? `FCC_PRESCALE_LAST : pre_cnt_ff - 3'd1;
            if (~flash_clock_divider_ff[`FCC_DIV_PRESCALE] | (pre_cnt_ff == 3'd0)) begin
                div_cnt_ff <= (div_cnt_ff == 6'd0) ? flash_clock_divider_ff[5:0]
                                                   : div_cnt_ff - 6'd1;
            end
        end
    end

    // Sequencer, buffer, executor and status flags. New sequences are
    // accepted while a burst runs so the next byte can be queued; any
    // other overlap is an ordering error.
    always @(posedge mclk) begin
        if (sys_rst) begin
            seq_ff                       <= S_IDLE;
            seq_addr_ff                  <= 16'h0000;
            seq_data_ff                  <= 8'h00;
            flash_command_ff             <= `FCC_RST_COMMAND;
            buffer_empty_flag_ff         <= 1'b1;
            command_complete_flag_ff     <= 1'b1;
            protection_violation_flag_ff <= 1'b0;
            access_error_flag_ff         <= 1'b0;
            blank_result_flag_ff         <= 1'b0;
            buf_addr_ff                  <= 16'h0000;
            buf_data_ff                  <= 8'h00;
            buf_cmd_ff                   <= 8'h00;
            arr_busy_ff                  <= 1'b0;
            arr_cmd_ff                   <= 8'h00;
            arr_addr_ff                  <= 16'h0000;
            arr_data_ff                  <= 8'h00;
            arr_pulse_ff                 <= 1'b0;
            pulse_cnt_ff                 <= 16'd0;
        end else begin
            // Flag clears first so any set below in this cycle wins
            if (acc_wr && paddr == `FCC_OFS_STATUS) begin
                if (pwdata[`FCC_ST_PVIOL]) begin
                    protection_violation_flag_ff <= 1'b0;
                end
                if (pwdata[`FCC_ST_ACCERR]) begin
                    access_error_flag_ff <= 1'b0;
                end
            end
            arr_pulse_ff <= arr_busy_ff & fclk_tick & ~stop_abort;
            // Step 1: array write with address and data
            if (seq_wr) begin
                if (seq_ff == S_IDLE && buffer_empty_flag_ff &&
                    (!arr_busy_ff || arr_cmd_ff == `FCC_CMD_BURST_PROG)) begin
                    seq_addr_ff <= arr_wr_addr;
                    seq_data_ff <= arr_wr_data;
                    seq_ff      <= S_DATA;
                end else begin
                    access_error_flag_ff <= 1'b1;
                    seq_ff               <= S_IDLE;
                end
            end
            // Step 2: command code
            if (cmd_wr) begin
                flash_command_ff <= pwdata[7:0];
                if (seq_ff == S_DATA) begin
                    seq_ff <= S_CMD;
                end else begin
                    access_error_flag_ff <= 1'b1;
                    seq_ff               <= S_IDLE;
                end
            end
            // Step 3: launch by writing one to the buffer-empty flag
            if (launch_wr && buffer_empty_flag_ff) begin
                seq_ff <= S_IDLE;
                // Blank check only reads the array, so it may run before the divider is set
                if (seq_ff != S_CMD || !cmd_legal ||
                    (!flash_clock_divider_ff[`FCC_DIV_LOADED] &&
                     flash_command_ff != `FCC_CMD_BLANK) ||
                    (arr_busy_ff && !cmd_is_burst)) begin
                    access_error_flag_ff <= 1'b1;
                end else if (prot_hit) begin
                    protection_violation_flag_ff <= 1'b1;
                end else begin
                    buffer_empty_flag_ff     <= 1'b0;
                    command_complete_flag_ff <= 1'b0;
                    blank_result_flag_ff     <= 1'b0;
                    buf_addr_ff              <= seq_addr_ff;
                    buf_data_ff              <= seq_data_ff;
                    buf_cmd_ff               <= flash_command_ff;
                end
            end
            // Executor: count flash-clock pulses, stop aborts the command
            if (stop_abort) begin
                arr_busy_ff              <= 1'b0;
                access_error_flag_ff     <= 1'b1;
                command_complete_flag_ff <= buffer_empty_flag_ff;
            end else if (arr_busy_ff) begin
                if (fclk_tick) begin
                    pulse_cnt_ff <= pulse_cnt_ff - 16'd1;
                end
                if (exe_done) begin
                    arr_busy_ff <= 1'b0;
                    if (arr_cmd_ff == `FCC_CMD_BLANK) begin
                        blank_result_flag_ff <= arr_blank;
                    end
                    command_complete_flag_ff <= buffer_empty_flag_ff;
                end
            end else if (!buffer_empty_flag_ff) begin
                // Buffered command moves into the array; buffer frees up
                arr_busy_ff          <= 1'b1;
                arr_cmd_ff           <= buf_cmd_ff;
                arr_addr_ff          <= buf_addr_ff;
                arr_data_ff          <= buf_data_ff;
                pulse_cnt_ff         <= pulses_for;
                buffer_empty_flag_ff <= 1'b1;
            end
            // A burst waiting behind one that just ended takes over next cycle
            if (exe_done && !buffer_empty_flag_ff) begin
                command_complete_flag_ff <= 1'b0;
            end
        end
    end

endmodule // fcc_top

// ===== sim/fcc_top_monitor.sv
// Concurrent checks on the flash command controller, seeing top ports only.
// Assumes one mclk domain; key enable, divider and protection are shadowed here.
`timescale 1ns/10ps
`include "fcc_map.vh"
module fcc_monitor (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_ff,
    input wire logic        pready_ff,
    input wire logic        arr_wr_en,
    input wire logic [15:0] arr_wr_addr,
    input wire logic [7:0]  arr_wr_data,
    input wire logic [7:0]  nonvolatile_protect_byte,
    input wire logic        dbg_prot_wr,
    input wire logic [7:0]  dbg_prot_data,
    input wire logic        stop_req,
    input wire logic        arr_busy_ff,
    input wire logic [7:0]  arr_cmd_ff,
    input wire logic [15:0] arr_addr_ff,
    input wire logic        arr_pulse_ff,
    input wire logic        key_wr_ff,
    input wire logic [2:0]  key_idx_ff,
    input wire logic [7:0]  key_data_ff
);
    logic       key_en_ff;
    logic       div_ld_ff;
    logic [7:0] prot_ff;
    logic       wr_acc;
    logic       key_hit;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Write access and key-range hit, decoded from the ports
    assign wr_acc  = psel && penable && pready_ff && pwrite;
    assign key_hit = arr_wr_en && arr_wr_addr >= 16'hffb0 && arr_wr_addr <= 16'hffb7;
    // Shadow state; protection follows reset load and debug writes only
    always @(posedge mclk) begin
        if (sys_rst) begin
            key_en_ff <= 1'b0;
            div_ld_ff <= 1'b0;
            prot_ff   <= nonvolatile_protect_byte;
        end else begin
            if (wr_acc && paddr == `FCC_OFS_CONFIG)
                key_en_ff <= pwdata[`FCC_CFG_KEY_WR_EN];
            if (wr_acc && paddr == `FCC_OFS_DIVIDER)
                div_ld_ff <= 1'b1;
            if (dbg_prot_wr)
                prot_ff <= dbg_prot_data;
        end
    end
    property p_key_route;
        key_en_ff && key_hit |=> key_wr_ff && key_idx_ff == $past(arr_wr_addr[2:0])
            && key_data_ff == $past(arr_wr_data);
    endproperty
    a_key_route: assert property (p_key_route) else $error("key write not routed");
    property p_key_off;
        !key_en_ff && key_hit |=> !key_wr_ff;
    endproperty
    a_key_off: assert property (p_key_off) else $error("key write while disabled");
    property p_prot_rd;
        psel && penable && pready_ff && !pwrite && paddr == `FCC_OFS_PROTECTION
            |-> prdata_ff == {24'h0, prot_ff};
    endproperty
    a_prot_rd: assert property (p_prot_rd) else $error("protection read wrong");
    property p_stop;
        stop_req && arr_busy_ff |-> ##[1:3] !arr_busy_ff;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_code;
        arr_busy_ff |-> arr_cmd_ff inside {`FCC_CMD_BLANK, `FCC_CMD_BYTE_PROG,
            `FCC_CMD_BURST_PROG, `FCC_CMD_PAGE_ERASE, `FCC_CMD_MASS_ERASE};
    endproperty
    a_code: assert property (p_code) else $error("illegal code executed");
    property p_prot;
        arr_busy_ff && !prot_ff[0] && arr_cmd_ff != `FCC_CMD_BLANK |->
            arr_cmd_ff != `FCC_CMD_MASS_ERASE && arr_addr_ff <= {prot_ff[7:1], 9'h1ff};
    endproperty
    a_prot: assert property (p_prot) else $error("protected area touched");
    property p_div;
        arr_busy_ff && arr_cmd_ff != `FCC_CMD_BLANK |-> div_ld_ff;
    endproperty
    a_div: assert property (p_div) else $error("run before divider written");
    property p_pulse;
        arr_pulse_ff |-> $past(arr_busy_ff) && !$past(stop_req);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse while idle");
endmodule // fcc_monitor

bind fcc_top fcc_monitor fcc_monitor_inst (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
    .nonvolatile_protect_byte(nonvolatile_protect_byte), .dbg_prot_wr(dbg_prot_wr),
    .dbg_prot_data(dbg_prot_data), .stop_req(stop_req), .arr_busy_ff(arr_busy_ff),
    .arr_cmd_ff(arr_cmd_ff), .arr_addr_ff(arr_addr_ff), .arr_pulse_ff(arr_pulse_ff),
    .key_wr_ff(key_wr_ff), .key_idx_ff(key_idx_ff), .key_data_ff(key_data_ff)
);

// ===== sim/fcc_top_bench.sv
// Self-checking bench for the flash command controller with a queue model.
// Assumes one APB access cycle and short page and mass counts of 3 and 5.
`timescale 1ns/10ps
`include "fcc_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module fcc_top_bench;
    logic        mclk, sys_rst, psel, penable, pwrite, pready_ff, pslverr_ff;
    logic [7:0]  paddr, arr_wr_data, nonvolatile_protect_byte, dbg_prot_data, prot;
    logic [31:0] pwdata, prdata_ff, rdata, exp_word;
    logic        arr_wr_en, dbg_prot_wr, stop_req, arr_blank, arr_busy_ff, arr_pulse_ff;
    logic [15:0] arr_wr_addr, arr_addr_ff, last_addr;
    logic [7:0]  arr_cmd_ff, arr_data_ff, key_data_ff;
    logic [2:0]  key_idx_ff;
    logic        key_wr_ff, slverr, exp_acc, exp_pv, exp_blank, div_ok, busy_q;
    logic [31:0] expq[$];
    logic [7:0]  codes[7];
    int          n_fail, total_checks;
    fcc_top #(.PULSES_PAGE(3), .PULSES_MASS(5)) fcc_top_inst (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr),
        .arr_wr_data(arr_wr_data), .nonvolatile_protect_byte(nonvolatile_protect_byte),
        .dbg_prot_wr(dbg_prot_wr), .dbg_prot_data(dbg_prot_data), .stop_req(stop_req),
        .arr_blank(arr_blank), .arr_busy_ff(arr_busy_ff), .arr_cmd_ff(arr_cmd_ff),
        .arr_addr_ff(arr_addr_ff), .arr_data_ff(arr_data_ff), .arr_pulse_ff(arr_pulse_ff),
        .key_wr_ff(key_wr_ff), .key_idx_ff(key_idx_ff), .key_data_ff(key_data_ff)
    );
    always #50 mclk = ~mclk;
    task test_done;
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound, then releases the bus
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready_ff !== 1'b1 && n < 20);
        if (pready_ff !== 1'b1) begin
            n_fail++;
            test_done();
        end
        rdata = prdata_ff;
        slverr = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task awr(input logic [15:0] a, input logic [7:0] d);
        arr_wr_en <= 1'b1;
        arr_wr_addr <= a;
        arr_wr_data <= d;
        @(posedge mclk);
        arr_wr_en <= 1'b0;
    endtask
    // Model decides the outcome before launch; accepted commands are queued
    task cmd(input logic [15:0] a, input logic [7:0] c, input logic bad);
        logic [7:0] d;
        logic       ok;
        int         n;
        d = 8'($urandom);
        ok = 1'b0;
        if (bad || (!div_ok && c != `FCC_CMD_BLANK) || !(c == codes[0] || c == codes[1]
            || c == codes[2] || c == codes[3] || c == codes[4]))
            exp_acc = 1'b1;
        else if (!prot[0] && c != `FCC_CMD_BLANK
                 && (c == `FCC_CMD_MASS_ERASE || a > {prot[7:1], 9'h1ff}))
            exp_pv = 1'b1;
        else begin
            expq.push_back({c, a, d});
            ok = 1'b1;
        end
        // Software may start a sequence only once the buffer is free
        n = 0;
        do begin
            apb(1'b0, `FCC_OFS_STATUS, 32'h0);
            n++;
        end while (rdata[7] !== 1'b1 && n < 50);
        `CHK(rdata[7], 1'b1)
        awr(a, d);
        // Blank level is read after its edge so a fresh value is seen
        if (ok) exp_blank = (c == `FCC_CMD_BLANK) && arr_blank;
        apb(1'b1, `FCC_OFS_COMMAND, {24'h0, c});
        apb(1'b1, `FCC_OFS_STATUS, 32'h80);
    endtask
    // Polls until all commands are complete, then compares the whole status
    task done_chk;
        int n;
        n = 0;
        do begin
            apb(1'b0, `FCC_OFS_STATUS, 32'h0);
            n++;
        end while (rdata[6] !== 1'b1 && n < 200);
        `CHK(rdata[7:0], {2'b11, exp_pv, exp_acc, 1'b0, exp_blank, 2'b00})
    endtask
    task clr;
        apb(1'b1, `FCC_OFS_STATUS, 32'h70);
        exp_acc = 1'b0;
        exp_pv = 1'b0;
    endtask
    // Each command reaching the array must be the next one the model accepted
    always @(posedge mclk) begin
        busy_q <= arr_busy_ff;
        last_addr <= arr_addr_ff;
        if (arr_busy_ff && (!busy_q || arr_addr_ff != last_addr)) begin
            if (expq.size() == 0) `CHK(1'b0, 1'b1)
            else begin
                exp_word = expq.pop_front();
                `CHK({arr_cmd_ff, arr_addr_ff, arr_data_ff}, exp_word)
            end
        end
    end
    initial begin
        mclk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        arr_wr_en = 0; arr_wr_addr = 0; arr_wr_data = 0; dbg_prot_wr = 0; dbg_prot_data = 0;
        stop_req = 0; arr_blank = 0; nonvolatile_protect_byte = 8'hfc; prot = 8'hfc;
        n_fail = 0; total_checks = 0; exp_acc = 0; exp_pv = 0; exp_blank = 0; div_ok = 0;
        codes = '{`FCC_CMD_BLANK, `FCC_CMD_BYTE_PROG, `FCC_CMD_BURST_PROG,
                  `FCC_CMD_PAGE_ERASE, `FCC_CMD_MASS_ERASE, 8'h33, 8'hff};
        void'($urandom(12009));
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        done_chk();
        apb(1'b1, `FCC_OFS_PROTECTION, 32'h01);
        apb(1'b0, `FCC_OFS_PROTECTION, 32'h0);
        `CHK(rdata, 32'hfc)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(slverr, 1'b1)
        cmd(16'h0000, `FCC_CMD_BLANK, 1'b0);
        done_chk();
        cmd(16'h1000, `FCC_CMD_BYTE_PROG, 1'b0);
        done_chk();
        clr();
        apb(1'b1, `FCC_OFS_STATUS, 32'h80);
        exp_acc = 1'b1;
        done_chk();
        clr();
        apb(1'b1, `FCC_OFS_DIVIDER, 32'h0);
        div_ok = 1'b1;
        apb(1'b0, `FCC_OFS_DIVIDER, 32'h0);
        `CHK(rdata, 32'h80)
        for (int i = 0; i < 7; i++) begin
            arr_blank <= 1'($urandom);
            cmd(16'($urandom_range(16'hfdff)), codes[i], 1'b0);
            done_chk();
            clr();
        end
        cmd(16'hfe00, `FCC_CMD_PAGE_ERASE, 1'b0);
        done_chk();
        clr();
        dbg_prot_wr <= 1'b1;
        dbg_prot_data <= 8'hfd;
        prot = 8'hfd;
        @(posedge mclk);
        dbg_prot_wr <= 1'b0;
        cmd(16'hffb3, `FCC_CMD_BYTE_PROG, 1'b0);
        done_chk();
        apb(1'b1, `FCC_OFS_CONFIG, 32'h20);
        apb(1'b0, `FCC_OFS_CONFIG, 32'h0);
        `CHK(rdata, 32'h20)
        awr(16'hffb5, 8'h5a);
        apb(1'b1, `FCC_OFS_CONFIG, 32'h0);
        // Slow flash clock so a second burst lands while the first still runs
        apb(1'b1, `FCC_OFS_DIVIDER, 32'h05);
        cmd(16'h0100, `FCC_CMD_BURST_PROG, 1'b0);
        cmd(16'h0101, `FCC_CMD_BURST_PROG, 1'b0);
        done_chk();
        cmd(16'h0200, `FCC_CMD_BURST_PROG, 1'b0);
        cmd(16'h0300, `FCC_CMD_BYTE_PROG, 1'b1);
        done_chk();
        clr();
        cmd(16'h0000, `FCC_CMD_MASS_ERASE, 1'b0);
        repeat (3) @(posedge mclk);
        stop_req <= 1'b1;
        exp_acc = 1'b1;
        done_chk();
        stop_req <= 1'b0;
        clr();
        nonvolatile_protect_byte <= 8'h51;
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, `FCC_OFS_PROTECTION, 32'h0);
        `CHK(rdata, 32'h51)
        apb(1'b0, `FCC_OFS_DIVIDER, 32'h0);
        `CHK(rdata, 32'h0)
        `CHK(expq.size(), 0)
        test_done();
    end
endmodule // fcc_top_bench
